// file: jnp_pkg.sv
// package: instruction codes, register widths and tap states for the nvm programming port
package jnp_pkg;

    localparam int JNP_IR_W   = 6;
    localparam int JNP_MON_W  = 12;
    localparam int JNP_SIG_W  = 16;
    localparam int JNP_ID_W   = 32;
    localparam int JNP_LADR_W = 75;
    localparam int JNP_LCOL_W = 81;
    localparam int JNP_SADR_W = 4;
    localparam int JNP_SCOL_W = 41;
    localparam int JNP_LCOLS  = 8;
    localparam int JNP_SCOLS  = 16;

    // identification value is arbitrary
    localparam logic [31:0] JNP_IDCODE_VAL = 32'h0000_0001;
    localparam logic [5:0]  JNP_IR_RESET   = 6'h19;
    localparam logic [1:0]  JNP_IR_CAPTURE = 2'h1;
    localparam logic [1:0]  JNP_ACT_EDGE   = 2'h2;

    typedef enum logic [5:0] {
        JNP_EXTEST       = 6'h00,
        JNP_LA_ADDR      = 6'h01,
        JNP_LC_SHIFT     = 6'h02,
        JNP_PT_ERASE     = 6'h03,
        JNP_RT_ERASE     = 6'h04,
        JNP_LC_PROG      = 6'h05,
        JNP_LOCK_PROG    = 6'h06,
        JNP_BYPASS7      = 6'h07,
        JNP_LC_READ      = 6'h08,
        JNP_DISCHARGE    = 6'h09,
        JNP_SA_ADDR      = 6'h0a,
        JNP_SC_SHIFT     = 6'h0b,
        JNP_SA_ERASE     = 6'h0c,
        JNP_SC_PROG      = 6'h0d,
        JNP_SC_READ      = 6'h0e,
        JNP_ALL_ERASE    = 6'h16,
        JNP_PROTECT      = 6'h17,
        JNP_WRITE_ENTRY  = 6'h18,
        JNP_IDENT        = 6'h19,
        JNP_WRITE_EXIT   = 6'h1a,
        JNP_MON_SNAP     = 6'h1b,
        JNP_SAMPLE       = 6'h1c,
        JNP_SIG_ERASE    = 6'h1d,
        JNP_SIG_ACCESS   = 6'h1e,
        JNP_SIG_PROG     = 6'h1f
    } jnp_instr_t;

    typedef enum logic [3:0] {
        JNP_TLR   = 4'h0, JNP_RTI   = 4'h1, JNP_SDRS  = 4'h3, JNP_CDR   = 4'h2,
        JNP_SDR   = 4'h6, JNP_E1DR  = 4'h7, JNP_PDR   = 4'h5, JNP_E2DR  = 4'h4,
        JNP_UDR   = 4'hc, JNP_SIRS  = 4'hd, JNP_CIR   = 4'hf, JNP_SIR   = 4'he,
        JNP_E1IR  = 4'ha, JNP_PIR   = 4'hb, JNP_E2IR  = 4'h9, JNP_UIR   = 4'h8
    } jnp_tap_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jnp_pins_t;

endpackage : jnp_pkg

// file: jnp_sync.sv
// two-flop synchroniser for the test port pins
`timescale 1ns/1ps
`default_nettype none
module jnp_sync
    import jnp_pkg::*;
#(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : jnp_sync
`default_nettype wire

// file: jnp_port.sv
// test-port instruction decoder and nonvolatile programming model
//
// Behaviour
// - decode 21 vendor instructions besides standard ones
// - logic address select loads address, forces protective outputs
// - logic column shift fills holding register, forces protective outputs
// - array erases act on second idle edge, write mode only
// - logic column program writes addressed column on second idle edge
// - lock program sets fuse; fuse then blocks design readback
// - logic column readback loads addressed column into register
// - discharge instruction holds outputs protected
// - setup address select loads setup address, forces protective outputs
// - setup column shift fills setup register, forces protective outputs
// - setup erase clears setup array on second idle edge
// - setup program writes addressed setup column on second idle edge
// - setup readback loads addressed setup column into register
// - whole erase clears all nonvolatile bits in write mode
// - protect instruction releases open drains, pulls gate drivers low
// - write entry enables, write exit or reset state cancels
// - ident instruction shifts identification code out
// - snapshot captures 12 monitor bits in capture-dr
// - signature erase clears signature in write mode
// - signature access loads stored signature into shift register
// - signature program stores register in write mode
// - instruction register is six bits
// - codes 011000 enter and 011010 leave write mode
// - code 011011 selects 12-bit snapshot register
// - code 011110 selects 16-bit signature register
`timescale 1ns/1ps
`default_nettype none
module jnp_port
    import jnp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire jnp_pins_t            pins,
    input  wire logic [JNP_MON_W-1:0] supply_monitor_bit,
    output logic                      tdo,
    output logic                      tdo_oe,
    output logic                      protect_outputs,
    output logic                      write_mode,
    output logic                      readout_lock_fuse
);
    // =====================================================
    // pin sampling and test clock edges
    jnp_pins_t pins_s;
    logic      tck_d;
    logic      tck_rise;
    logic      tck_fall;

    jnp_sync #(.W(3)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (pins),
        .q       (pins_s)
    );

    // comparator levels are asynchronous too; a bit moving at capture may land
    // on either side, which is harmless since each bit is an independent comparator
    logic [JNP_MON_W-1:0] mon_s;

    jnp_sync #(.W(JNP_MON_W)) u_mon_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (supply_monitor_bit),
        .q       (mon_s)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= pins_s.tck;
        end
    end
    assign tck_rise = pins_s.tck & ~tck_d;
    assign tck_fall = ~pins_s.tck & tck_d;

    // =====================================================
    // tap state machine
    jnp_tap_t state;
    jnp_tap_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            JNP_TLR:  next_state = pins_s.tms ? JNP_TLR  : JNP_RTI;
            JNP_RTI:  next_state = pins_s.tms ? JNP_SDRS : JNP_RTI;
            JNP_SDRS: next_state = pins_s.tms ? JNP_SIRS : JNP_CDR;
            JNP_CDR:  next_state = pins_s.tms ? JNP_E1DR : JNP_SDR;
            JNP_SDR:  next_state = pins_s.tms ? JNP_E1DR : JNP_SDR;
            JNP_E1DR: next_state = pins_s.tms ? JNP_UDR  : JNP_PDR;
            JNP_PDR:  next_state = pins_s.tms ? JNP_E2DR : JNP_PDR;
            JNP_E2DR: next_state = pins_s.tms ? JNP_UDR  : JNP_SDR;
            JNP_UDR:  next_state = pins_s.tms ? JNP_SDRS : JNP_RTI;
            JNP_SIRS: next_state = pins_s.tms ? JNP_TLR  : JNP_CIR;
            JNP_CIR:  next_state = pins_s.tms ? JNP_E1IR : JNP_SIR;
            JNP_SIR:  next_state = pins_s.tms ? JNP_E1IR : JNP_SIR;
            JNP_E1IR: next_state = pins_s.tms ? JNP_UIR  : JNP_PIR;
            JNP_PIR:  next_state = pins_s.tms ? JNP_E2IR : JNP_PIR;
            JNP_E2IR: next_state = pins_s.tms ? JNP_UIR  : JNP_SIR;
            JNP_UIR:  next_state = pins_s.tms ? JNP_SDRS : JNP_RTI;
            default:  next_state = JNP_TLR;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= JNP_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // =====================================================
    // instruction register, six bits
    logic [JNP_IR_W-1:0] ir_shift;
    jnp_instr_t          instr;

    // codes missing from the table fall back to bypass rather than an unnamed enum value
    function automatic jnp_instr_t decode_instr(input logic [JNP_IR_W-1:0] code);
        if (code inside {[JNP_EXTEST:JNP_SC_READ], [JNP_ALL_ERASE:JNP_SIG_PROG]}) begin
            decode_instr = jnp_instr_t'(code);
        end else begin
            decode_instr = JNP_BYPASS7;
        end
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_shift <= '0;
            instr    <= JNP_IDENT;
        end else if (tck_rise) begin
            if (state == JNP_TLR) begin
                instr <= JNP_IDENT;
            end else if (state == JNP_CIR) begin
                ir_shift <= {4'h0, JNP_IR_CAPTURE};
            end else if (state == JNP_SIR) begin
                ir_shift <= {pins_s.tdi, ir_shift[JNP_IR_W-1:1]};
            end else if (state == JNP_UIR) begin
                instr <= decode_instr(ir_shift);
            end
        end
    end

    // instructions that put outputs into the protective condition
    function automatic logic is_protecting(input jnp_instr_t i);
        case (i)
            JNP_LA_ADDR,
            JNP_LC_SHIFT,
            JNP_PT_ERASE,
            JNP_RT_ERASE,
            JNP_LC_PROG,
            JNP_LOCK_PROG,
            JNP_LC_READ,
            JNP_DISCHARGE,
            JNP_SA_ADDR,
            JNP_SC_SHIFT,
            JNP_SA_ERASE,
            JNP_SC_PROG,
            JNP_SC_READ,
            JNP_ALL_ERASE,
            JNP_PROTECT,
            JNP_WRITE_ENTRY,
            JNP_SIG_ERASE,
            JNP_SIG_PROG:    is_protecting = 1'b1;
            default:         is_protecting = 1'b0;
        endcase
    endfunction

    // =====================================================
    // write mode and protective condition; both applied after update-ir
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_mode      <= 1'b0;
            protect_outputs <= 1'b0;
        end else if (tck_rise) begin
            if (state == JNP_TLR) begin
                write_mode      <= 1'b0;
                protect_outputs <= 1'b0;
            end else if (state == JNP_UIR) begin
                if (ir_shift == JNP_WRITE_ENTRY) begin
                    write_mode <= 1'b1;
                end else if (ir_shift == JNP_WRITE_EXIT) begin
                    write_mode      <= 1'b0;
                    protect_outputs <= 1'b0;
                end
                // protective instructions latch it; only exit or reset releases it
                if (is_protecting(decode_instr(ir_shift))) begin
                    protect_outputs <= 1'b1;
                end
            end
        end
    end

    // =====================================================
    // idle edge counter: actions fire on the second rising edge in run-test/idle
    logic [1:0] idle_cnt;
    logic       act;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_cnt <= '0;
        end else if (tck_rise) begin
            if (state != JNP_RTI) begin
                idle_cnt <= '0;
            end else if (idle_cnt != JNP_ACT_EDGE) begin
                idle_cnt <= idle_cnt + 2'h1;
            end
        end
    end
    assign act = tck_rise && state == JNP_RTI && idle_cnt == (JNP_ACT_EDGE - 2'h1) && write_mode;

    // =====================================================
    // nonvolatile storage model and data registers
    logic [JNP_LCOL_W-1:0] logic_col   [JNP_LCOLS];
    logic [JNP_SCOL_W-1:0] setup_col   [JNP_SCOLS];
    logic [JNP_SIG_W-1:0]  user_signature;
    logic [JNP_LADR_W-1:0] la_addr;
    logic [JNP_LCOL_W-1:0] lc_data;
    logic [JNP_SADR_W-1:0] sa_addr;
    logic [JNP_SCOL_W-1:0] sc_data;
    logic [JNP_MON_W-1:0]  supply_monitor_snapshot;
    logic [JNP_SIG_W-1:0]  user_signature_shift;
    logic [JNP_ID_W-1:0]   id_shift;
    logic                  bypass_bit;
    logic [2:0]            la_idx;

    assign la_idx = la_addr[2:0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < JNP_LCOLS; i++) begin
                logic_col[i] <= '0;
            end
            for (int i = 0; i < JNP_SCOLS; i++) begin
                setup_col[i] <= '0;
            end
            user_signature    <= '0;
            readout_lock_fuse <= 1'b0;
        end else if (act) begin
            case (instr)
                JNP_PT_ERASE, JNP_RT_ERASE: begin
                    for (int i = 0; i < JNP_LCOLS; i++) begin
                        logic_col[i] <= '0;
                    end
                end
                JNP_LC_PROG:   logic_col[la_idx] <= lc_data;
                JNP_LOCK_PROG: readout_lock_fuse <= 1'b1;
                JNP_SA_ERASE: begin
                    for (int i = 0; i < JNP_SCOLS; i++) begin
                        setup_col[i] <= '0;
                    end
                end
                JNP_SC_PROG: setup_col[sa_addr] <= sc_data;
                JNP_ALL_ERASE: begin
                    for (int i = 0; i < JNP_LCOLS; i++) begin
                        logic_col[i] <= '0;
                    end
                    for (int i = 0; i < JNP_SCOLS; i++) begin
                        setup_col[i] <= '0;
                    end
                    user_signature    <= '0;
                    readout_lock_fuse <= 1'b0;
                end
                JNP_SIG_ERASE: user_signature <= '0;
                JNP_SIG_PROG:  user_signature <= user_signature_shift;
                default: ;
            endcase
        end
    end

    // capture and shift of the selected data register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            la_addr                 <= '0;
            lc_data                 <= '0;
            sa_addr                 <= '0;
            sc_data                 <= '0;
            supply_monitor_snapshot <= '0;
            user_signature_shift    <= '0;
            id_shift                <= '0;
            bypass_bit              <= 1'b0;
        end else if (tck_rise) begin
            if (state == JNP_CDR) begin
                bypass_bit <= 1'b0;
                case (instr)
                    JNP_IDENT:    id_shift <= JNP_IDCODE_VAL;
                    JNP_MON_SNAP: supply_monitor_snapshot <= mon_s;
                    // lock fuse hides stored design from readback
                    JNP_LC_READ:  lc_data <= readout_lock_fuse ? '0 : logic_col[la_idx];
                    JNP_SC_READ:  sc_data <= readout_lock_fuse ? '0 : setup_col[sa_addr];
                    JNP_SIG_ACCESS: user_signature_shift <= user_signature;
                    default: ;
                endcase
            end else if (state == JNP_SDR) begin
                case (instr)
                    JNP_LA_ADDR:  la_addr <= {pins_s.tdi, la_addr[JNP_LADR_W-1:1]};
                    JNP_LC_SHIFT, JNP_LC_READ: lc_data <= {pins_s.tdi, lc_data[JNP_LCOL_W-1:1]};
                    JNP_SA_ADDR:  sa_addr <= {pins_s.tdi, sa_addr[JNP_SADR_W-1:1]};
                    JNP_SC_SHIFT, JNP_SC_READ: sc_data <= {pins_s.tdi, sc_data[JNP_SCOL_W-1:1]};
                    JNP_MON_SNAP: supply_monitor_snapshot <= {pins_s.tdi, supply_monitor_snapshot[JNP_MON_W-1:1]};
                    JNP_SIG_ACCESS: user_signature_shift <= {pins_s.tdi, user_signature_shift[JNP_SIG_W-1:1]};
                    JNP_IDENT:    id_shift <= {pins_s.tdi, id_shift[JNP_ID_W-1:1]};
                    default:      bypass_bit <= pins_s.tdi;
                endcase
            end
        end
    end

    // =====================================================
    // test data out changes on falling test clock edge
    logic next_tdo;

    always_comb begin
        next_tdo = bypass_bit;
        if (state == JNP_SIR) begin
            next_tdo = ir_shift[0];
        end else begin
            case (instr)
                JNP_LA_ADDR:               next_tdo = la_addr[0];
                JNP_LC_SHIFT, JNP_LC_READ: next_tdo = lc_data[0];
                JNP_SA_ADDR:               next_tdo = sa_addr[0];
                JNP_SC_SHIFT, JNP_SC_READ: next_tdo = sc_data[0];
                JNP_MON_SNAP:              next_tdo = supply_monitor_snapshot[0];
                JNP_SIG_ACCESS:            next_tdo = user_signature_shift[0];
                JNP_IDENT:                 next_tdo = id_shift[0];
                default:                   next_tdo = bypass_bit;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= next_tdo;
            tdo_oe <= (state == JNP_SDR) || (state == JNP_SIR);
        end
    end
endmodule : jnp_port
`default_nettype wire

// file: jnp_port_assertions.sv
// checker for the nvm programming port outputs
`timescale 1ns/1ps
`default_nettype none
module jnp_port_assertions
    import jnp_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire jnp_pins_t            pins,
    input wire logic [JNP_MON_W-1:0] supply_monitor_bit,
    input wire logic                 tdo,
    input wire logic                 tdo_oe,
    input wire logic                 protect_outputs,
    input wire logic                 write_mode,
    input wire logic                 readout_lock_fuse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ====================================
    // tck edge age: pins are async, design sees them after sync
    logic       tck_q;
    logic [3:0] rise_age;
    logic [3:0] fall_age;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_q    <= 1'b0;
            rise_age <= 4'hf;
            fall_age <= 4'hf;
        end else begin
            tck_q    <= pins.tck;
            rise_age <= (pins.tck && !tck_q) ? 4'h0 : ((rise_age == 4'hf) ? rise_age : rise_age + 4'h1);
            fall_age <= (!pins.tck && tck_q) ? 4'h0 : ((fall_age == 4'hf) ? fall_age : fall_age + 4'h1);
        end
    end
    // ====================================
    // properties
    sequence s_mode_on;
        $rose(write_mode);
    endsequence
    sequence s_mode_off;
        $fell(write_mode);
    endsequence
    property p_entry_protects;
        s_mode_on |-> protect_outputs;
    endproperty
    property p_exit_releases;
        s_mode_off |-> ##[0:1] !protect_outputs;
    endproperty
    property p_lock_needs_mode;
        $rose(readout_lock_fuse) |-> write_mode && protect_outputs;
    endproperty
    property p_lock_clear_needs_mode;
        $fell(readout_lock_fuse) |-> write_mode;
    endproperty
    property p_protect_hold;
        $fell(protect_outputs) |-> !write_mode;
    endproperty
    property p_state_on_tck;
        $changed({write_mode, protect_outputs, readout_lock_fuse}) |-> rise_age inside {[1:6]};
    endproperty
    property p_tdo_on_fall;
        $changed(tdo) |-> fall_age inside {[1:6]};
    endproperty
    property p_oe_on_fall;
        $changed(tdo_oe) |-> fall_age inside {[1:6]};
    endproperty
    a_entry_protects: assert property (p_entry_protects) else $error("entry without protect");
    a_exit_releases: assert property (p_exit_releases) else $error("protect kept after exit");
    a_lock_needs_mode: assert property (p_lock_needs_mode) else $error("fuse set outside mode");
    a_lock_clear_needs_mode: assert property (p_lock_clear_needs_mode) else $error("fuse cleared");
    a_protect_hold: assert property (p_protect_hold) else $error("protect dropped in mode");
    a_state_on_tck: assert property (p_state_on_tck) else $error("state moved off tck");
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off tck fall");
    a_oe_on_fall: assert property (p_oe_on_fall) else $error("tdo_oe moved off tck fall");
endmodule // jnp_port_assertions
bind jnp_port jnp_port_assertions u_chk (.clk(clk), .reset_n(reset_n), .pins(pins),
    .supply_monitor_bit(supply_monitor_bit), .tdo(tdo), .tdo_oe(tdo_oe),
    .protect_outputs(protect_outputs), .write_mode(write_mode), .readout_lock_fuse(readout_lock_fuse));
`default_nettype wire

// file: jnp_master.sv
// test-port master model for the programming pins
`timescale 1ns/1ps
`default_nettype none
module jnp_master
    import jnp_pkg::*;
(
    input  wire logic      tdo,
    input  wire logic      tdo_oe,
    output var  jnp_pins_t pins
);
    // ====================================
    // tck stands low between frames; 48 ns period
    // tdo_oe as seen at each shifting edge of the latest scan
    logic oe_at_rise;
    logic oe_ok;
    initial pins = '0;
    task automatic bit_cycle(input logic tms, input logic tdi, output logic tdo_bit);
        pins.tms = tms;
        pins.tdi = tdi;
        #24 pins.tck = 1'b1;
        tdo_bit = tdo;
        oe_at_rise = tdo_oe;
        #24 pins.tck = 1'b0;
    endtask
    task automatic step(input logic tms);
        logic d;
        bit_cycle(tms, pins.tdi, d);
    endtask
    task automatic tap_reset();
        repeat (5) step(1'b1);
        step(1'b0);
    endtask
    task automatic idle(input int n);
        repeat (n) step(1'b0);
    endtask
    // from idle, shift lsb first, back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic d;
        dout = '0;
        oe_ok = 1'b1;
        step(1'b1);
        if (ir) step(1'b1);
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < n; i++) begin
            bit_cycle(i == n - 1, din[i], d);
            dout[i] = d;
            oe_ok = oe_ok & oe_at_rise;
        end
        step(1'b1);
        step(1'b0);
        // no stale level left on tdi
        pins.tdi = ~pins.tdi;
    endtask
endmodule // jnp_master
`default_nettype wire

// file: jnp_port_tb.sv
// self-checking testbench for the nvm programming port
`timescale 1ns/1ps
`default_nettype none
module jnp_port_tb;
    import jnp_pkg::*;
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    jnp_pins_t            pins;
    logic [JNP_MON_W-1:0] mon = '0;
    logic                 tdo;
    logic                 tdo_oe;
    logic                 protect_outputs;
    logic                 write_mode;
    logic                 readout_lock_fuse;
    logic [127:0]         rd;
    int                   bad_count = 0;
    int                   compares = 0;
    int                   cycles = 0;
    always #2.5 clk = ~clk;
    jnp_port DUT (
        .clk                (clk),
        .reset_n            (reset_n),
        .pins               (pins),
        .supply_monitor_bit (mon),
        .tdo                (tdo),
        .tdo_oe             (tdo_oe),
        .protect_outputs    (protect_outputs),
        .write_mode         (write_mode),
        .readout_lock_fuse  (readout_lock_fuse)
    );
    jnp_master MST (
        .tdo    (tdo),
        .tdo_oe (tdo_oe),
        .pins   (pins)
    );
    // ====================================
    // helpers
    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic flags(input logic [2:0] exp, input string what);
        check({125'h0, write_mode, protect_outputs, readout_lock_fuse}, {125'h0, exp}, what);
    endtask
    task automatic instr(input jnp_instr_t c);
        MST.scan(1'b1, JNP_IR_W, 128'(c), rd);
    endtask
    task automatic dr(input int n, input logic [127:0] d);
        MST.scan(1'b0, n, d, rd);
    endtask
    task automatic complete_run();
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ====================================
    // scenarios
    task automatic t_ident();
        MST.tap_reset();
        flags(3'b000, "flags after reset");
        dr(JNP_ID_W, '0);
        check(rd, 128'(JNP_IDCODE_VAL), "id code");
        check(128'(MST.oe_ok), 128'h1, "tdo enable while shifting");
        check(128'(tdo_oe), 128'h0, "tdo enable when idle");
        instr(JNP_SAMPLE);
        dr(4, 128'hb);
        check(rd, 128'h6, "bypass path");
    endtask
    task automatic t_refused();
        instr(JNP_LOCK_PROG);
        check(rd, 128'h01, "ir capture");
        MST.idle(2);
        flags(3'b010, "lock outside mode");
        instr(JNP_PROTECT);
        instr(JNP_IDENT);
        flags(3'b010, "protect held");
        MST.tap_reset();
        flags(3'b000, "reset state clears");
        instr(JNP_PROTECT);
        flags(3'b010, "protect instruction");
        MST.tap_reset();
    endtask
    task automatic t_signature();
        instr(JNP_WRITE_ENTRY);
        flags(3'b110, "write entry");
        instr(JNP_SIG_ERASE);
        MST.idle(2);
        instr(JNP_SIG_ACCESS);
        dr(JNP_SIG_W, 128'ha5c3);
        instr(JNP_SIG_PROG);
        MST.idle(2);
        instr(JNP_SIG_ACCESS);
        dr(JNP_SIG_W, 128'h0f0f);
        check(rd, 128'ha5c3, "stored signature");
        instr(JNP_SIG_ACCESS);
        dr(JNP_SIG_W, '0);
        check(rd, 128'ha5c3, "signature reloaded");
        instr(JNP_SIG_ERASE);
        MST.idle(2);
        instr(JNP_SIG_ACCESS);
        dr(JNP_SIG_W, '0);
        check(rd, '0, "signature erased");
    endtask
    task automatic t_monitor(input logic [JNP_MON_W-1:0] v);
        @(posedge clk);
        #1 mon = v;
        instr(JNP_MON_SNAP);
        dr(JNP_MON_W, '0);
        check(rd, 128'(v), "monitor snapshot");
    endtask
    task automatic t_array(input jnp_instr_t er, input jnp_instr_t er2, input jnp_instr_t ad, input int aw,
                           input jnp_instr_t sh, input int w, input jnp_instr_t pr, input jnp_instr_t rb,
                           input logic [127:0] a, input logic [127:0] pat);
        logic [127:0] m;
        m = (128'h1 << w) - 128'h1;
        instr(er);
        MST.idle(2);
        instr(er2);
        MST.idle(2);
        instr(ad);
        dr(aw, a);
        instr(sh);
        dr(w, pat & m);
        instr(pr);
        MST.idle(2);
        instr(sh);
        dr(w, ~pat & m);
        instr(rb);
        MST.idle(2);
        dr(w, '0);
        check(rd, pat & m, "column readback");
        flags(3'b110, "protect during array work");
    endtask
    task automatic t_lock();
        instr(JNP_LOCK_PROG);
        MST.idle(2);
        flags(3'b111, "fuse set");
        instr(JNP_SC_READ);
        MST.idle(2);
        dr(JNP_SCOL_W, '0);
        check(rd, '0, "locked readback");
        instr(JNP_ALL_ERASE);
        MST.idle(2);
        flags(3'b110, "whole erase");
        instr(JNP_DISCHARGE);
        MST.idle(2);
        flags(3'b110, "discharge");
        instr(JNP_WRITE_EXIT);
        flags(3'b000, "write exit");
        instr(JNP_WRITE_ENTRY);
        MST.tap_reset();
        flags(3'b000, "reset state cancels");
    endtask
    // ====================================
    // main sequence and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 60000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        t_ident();
        t_refused();
        t_monitor(12'ha5c);
        t_monitor(12'h3a1);
        t_signature();
        t_array(JNP_SA_ERASE, JNP_SA_ERASE, JNP_SA_ADDR, JNP_SADR_W, JNP_SC_SHIFT, JNP_SCOL_W,
                JNP_SC_PROG, JNP_SC_READ, 128'h9, 128'h1_2345_6789_abcd_ef01);
        t_array(JNP_PT_ERASE, JNP_RT_ERASE, JNP_LA_ADDR, JNP_LADR_W, JNP_LC_SHIFT, JNP_LCOL_W,
                JNP_LC_PROG, JNP_LC_READ, 128'h3, 128'h1_5a5a_0ff0_1234_c3c3_8765_9abc);
        t_lock();
        complete_run();
    end
endmodule // jnp_port_tb
`default_nettype wire
